// >>> shared/vme_bank_consts.vh
`ifndef VME_BANK_CONSTS_VH
`define VME_BANK_CONSTS_VH

//--------------------------------
// register offsets
//--------------------------------
`define OFS_FIRMWARE_REVISION 16'h1000
`define OFS_SLOT_POSITION 16'h1002
`define OFS_CHAIN_BROADCAST_ADDRESS 16'h1004
`define OFS_CONTROL_SET 16'h1006
`define OFS_CONTROL_CLEAR 16'h1008
`define OFS_INTERRUPT_LEVEL 16'h100A
`define OFS_INTERRUPT_VECTOR 16'h100C
`define OFS_MODULE_STATUS 16'h100E

//--------------------------------
// control bit positions
//--------------------------------
`define CTRL_BUS_ERROR_BIT 3
`define CTRL_RELOCATION_BIT 4
`define CTRL_SOFT_RESET_BIT 7
`define CTRL_WRITABLE_MASK 16'h0098
`define CTRL_RESET 16'h0000

//--------------------------------
// status bit positions
//--------------------------------
`define STAT_LOCAL_DATA_READY_BIT 0
`define STAT_CHAIN_DATA_READY_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_CHAIN_BUSY_BIT 3
`define STAT_SLOT_MISSING_BIT 4
`define STAT_PURGED_BIT 5
`define STAT_TERM_ALL_ON_BIT 6
`define STAT_TERM_ALL_OFF_BIT 7
`define STAT_EVENT_THRESHOLD_BIT 8

//--------------------------------
// reset values and timing
//--------------------------------
`define SLOT_POSITION_RESET 5'h1F
`define CHAIN_ADDRESS_RESET 8'hAA
`define INTERRUPT_LEVEL_RESET 3'h0
`define INTERRUPT_VECTOR_RESET 8'h00
`define SLOT_LOAD_WAIT 3'h5

`endif

// >>> verilog/pin_synchronizer.v
`timescale 1ns/1ps
//--------------------------------
// three-stage pin synchroniser
//--------------------------------
module pin_synchronizer #(
	parameter WIDTH = 1
) (
	input wire clk_in,
	input wire reset_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	integer i;

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
			stage3 <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			// bit changes once stages two and three agree
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end
endmodule // pin_synchronizer

// >>> verilog/vme_control_bits.v
`timescale 1ns/1ps
`include "vme_bank_consts.vh"
//--------------------------------
// set/clear control bits
//--------------------------------
module vme_control_bits (
	input wire clk_in,
	input wire reset_in,
	input wire set_write_in,
	input wire clear_write_in,
	input wire [15:0] write_data_in,
	input wire bus_error_event_in,
	input wire software_reset_in,
	output reg [15:0] control_out
);
	reg [15:0] next_control;

	always @* begin
		next_control = control_out;
		if (software_reset_in) begin
			next_control[`CTRL_BUS_ERROR_BIT] = 1'b0;
		end
		if (clear_write_in) begin
			next_control = next_control & ~(write_data_in & `CTRL_WRITABLE_MASK);
		end
		if (set_write_in) begin
			next_control = next_control | (write_data_in & `CTRL_WRITABLE_MASK);
		end
		// hardware event wins over any clear
		if (bus_error_event_in) begin
			next_control[`CTRL_BUS_ERROR_BIT] = 1'b1;
		end
	end

	// other bits survive software reset
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			control_out <= `CTRL_RESET;
		end else begin
			control_out <= next_control;
		end
	end
endmodule // vme_control_bits

// >>> verilog/vme_module_control_status_bank.v
`timescale 1ns/1ps
`include "vme_bank_consts.vh"
// Operation
// - read-only revision word, four hex digits
// - slot position loaded from lines on reset
// - five slot bits map address A23..A19
// - no aux connector: writable, default ones
// - aux connector: slot write not answered
// - written slot value applies after software reset
// - broadcast address byte, resets to 0xAA
// - set register: ones set bits, readable
// - bit 0x10 selects relocation base address
// - bus error flag, cleared by resets
// - soft reset holds until cleared
// - other control bits: hardware reset only
// - clear register: ones clear bits, readable
// - three-bit interrupt level, zero disables
// - vector driven during interrupt acknowledge
// - data ready when complete event stored
// - chain ready and busy are line ORs
// - busy: conversion, reset, full, memtest
// - slot missing when no backplane slot
// - purged once chain data sent
// - termination all-on, all-off, both zero mixed
// - threshold: trigger >= count, irq requested; code also needs a nonzero interrupt level

//--------------------------------
// control and status register bank
//--------------------------------
module vme_module_control_status_bank #(
	// arbitrary revision value
	parameter [15:0] FIRMWARE_REVISION = 16'h0A00
) (
	input wire clk_in,
	input wire reset_in,
	input wire software_reset_in,
	input wire aux_slot_connector_in,
	input wire [4:0] slot_lines_in,
	input wire [15:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	input wire iack_in,
	input wire bus_error_event_in,
	input wire [4:0] events_stored_in,
	input wire [4:0] event_trigger_in,
	input wire irq_requested_in,
	input wire conversion_active_in,
	input wire buffer_full_in,
	input wire memory_test_in,
	input wire chain_purged_in,
	input wire chain_ready_line_in,
	input wire chain_busy_line_in,
	input wire term_all_on_in,
	input wire term_all_off_in,
	output reg [15:0] reg_rdata_out,
	output reg reg_ack_out,
	output wire [4:0] slot_position_out,
	output wire [7:0] chain_broadcast_address_out,
	output wire base_from_relocation_out,
	output wire bus_error_flag_out,
	output wire module_reset_out,
	output wire [2:0] interrupt_level_out,
	output wire [7:0] interrupt_vector_out,
	output wire local_data_ready_out,
	output wire local_busy_out
);
	//--------------------------------
	// helper functions
	//--------------------------------
	// one register offset match
	function offset_hit;
		input [15:0] addr;
		input [15:0] offset;
		begin
			offset_hit = (addr == offset);
		end
	endfunction

	// byte register in the low half
	function [15:0] byte_word;
		input [7:0] value;
		begin
			byte_word = {8'h00, value};
		end
	endfunction

	//--------------------------------
	// pin synchronisation
	//--------------------------------
	wire aux_sync;
	wire [4:0] slot_lines_sync;
	wire chain_ready_sync;
	wire chain_busy_sync;
	wire term_on_sync;
	wire term_off_sync;

	// all pins share one synchroniser
	pin_synchronizer #(
		.WIDTH(10)
	) u_pins (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.async_in({aux_slot_connector_in, slot_lines_in, chain_ready_line_in,
			chain_busy_line_in, term_all_on_in, term_all_off_in}),
		.sync_out({aux_sync, slot_lines_sync, chain_ready_sync,
			chain_busy_sync, term_on_sync, term_off_sync})
	);

	//--------------------------------
	// address decode
	//--------------------------------
	wire hit_revision = offset_hit(reg_addr_in, `OFS_FIRMWARE_REVISION);
	wire hit_slot = offset_hit(reg_addr_in, `OFS_SLOT_POSITION);
	wire hit_chain = offset_hit(reg_addr_in, `OFS_CHAIN_BROADCAST_ADDRESS);
	wire hit_set = offset_hit(reg_addr_in, `OFS_CONTROL_SET);
	wire hit_clear = offset_hit(reg_addr_in, `OFS_CONTROL_CLEAR);
	wire hit_level = offset_hit(reg_addr_in, `OFS_INTERRUPT_LEVEL);
	wire hit_vector = offset_hit(reg_addr_in, `OFS_INTERRUPT_VECTOR);
	wire hit_status = offset_hit(reg_addr_in, `OFS_MODULE_STATUS);
	// only the eight offsets answer
	wire hit_any = hit_revision | hit_slot | hit_chain | hit_set |
		hit_clear | hit_level | hit_vector | hit_status;

	// slot writes are refused on boards with the aux connector
	wire slot_write_refused = reg_write_in & hit_slot & aux_sync;
	wire write_taken = reg_write_in & hit_any & ~slot_write_refused;
	wire read_taken = reg_read_in & hit_any;

	//--------------------------------
	// control bits
	//--------------------------------
	wire [15:0] control_bits;
	wire soft_reset_hold = control_bits[`CTRL_SOFT_RESET_BIT];
	// hold bit keeps software reset asserted
	wire software_reset = software_reset_in | soft_reset_hold;

	vme_control_bits u_control (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.set_write_in(write_taken & hit_set),
		.clear_write_in(write_taken & hit_clear),
		.write_data_in(reg_wdata_in),
		.bus_error_event_in(bus_error_event_in),
		.software_reset_in(software_reset),
		.control_out(control_bits)
	);

	//--------------------------------
	// slot position
	//--------------------------------
	reg [4:0] slot_written;
	reg [4:0] slot_position;
	reg slot_load_pending;
	reg [2:0] slot_load_wait;

	// written value kept through software reset, used at next load
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slot_written <= `SLOT_POSITION_RESET;
		end else if (write_taken & hit_slot) begin
			slot_written <= reg_wdata_in[4:0];
		end
	end

	// load waits for the synchroniser to fill after any reset
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slot_position <= `SLOT_POSITION_RESET;
			slot_load_pending <= 1'b1;
			slot_load_wait <= `SLOT_LOAD_WAIT;
		end else if (software_reset) begin
			slot_load_pending <= 1'b1;
			slot_load_wait <= `SLOT_LOAD_WAIT;
		end else if (slot_load_pending) begin
			if (slot_load_wait != 3'h0) begin
				slot_load_wait <= slot_load_wait - 3'h1;
			end else begin
				slot_load_pending <= 1'b0;
				// strap low: software-written slot applies
				if (aux_sync) begin
					slot_position <= slot_lines_sync;
				end else begin
					slot_position <= slot_written;
				end
			end
		end
	end

	//--------------------------------
	// broadcast address and interrupt setup
	//--------------------------------
	reg [7:0] chain_address;
	reg [2:0] interrupt_level;
	reg [7:0] interrupt_vector;

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			chain_address <= `CHAIN_ADDRESS_RESET;
			interrupt_level <= `INTERRUPT_LEVEL_RESET;
			interrupt_vector <= `INTERRUPT_VECTOR_RESET;
		end else begin
			if (write_taken & hit_chain) begin
				chain_address <= reg_wdata_in[7:0];
			end
			if (write_taken & hit_level) begin
				interrupt_level <= reg_wdata_in[2:0];
			end
			if (write_taken & hit_vector) begin
				interrupt_vector <= reg_wdata_in[7:0];
			end
		end
	end

	wire interrupt_enabled = (interrupt_level != 3'h0);
	// vector answer only when no read or write is taken
	wire iack_taken = iack_in & interrupt_enabled & ~write_taken & ~read_taken;

	// board counts as resetting during hold and slot load
	wire resetting = software_reset | slot_load_pending;

	//--------------------------------
	// status derivation
	//--------------------------------
	reg local_data_ready;
	reg local_busy;
	reg event_threshold_flag;
	reg chain_data_ready;
	reg chain_busy;
	reg purged;

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			local_data_ready <= 1'b0;
			local_busy <= 1'b1;
			event_threshold_flag <= 1'b0;
			chain_data_ready <= 1'b0;
			chain_busy <= 1'b0;
			purged <= 1'b0;
		end else begin
			local_data_ready <= (events_stored_in != 5'h00);
			local_busy <= conversion_active_in | resetting | buffer_full_in | memory_test_in;
			// threshold needs a live interrupt level
			event_threshold_flag <= (event_trigger_in >= events_stored_in) &
				irq_requested_in & interrupt_enabled;
			// chain lines arrive already ORed on the wire
			chain_data_ready <= chain_ready_sync;
			chain_busy <= chain_busy_sync;
			purged <= chain_purged_in;
		end
	end

	reg [15:0] status_word;

	always @* begin
		status_word = 16'h0000;
		status_word[`STAT_LOCAL_DATA_READY_BIT] = local_data_ready;
		status_word[`STAT_CHAIN_DATA_READY_BIT] = chain_data_ready;
		status_word[`STAT_BUSY_BIT] = local_busy;
		status_word[`STAT_CHAIN_BUSY_BIT] = chain_busy;
		status_word[`STAT_SLOT_MISSING_BIT] = ~aux_sync;
		status_word[`STAT_PURGED_BIT] = purged;
		status_word[`STAT_TERM_ALL_ON_BIT] = term_on_sync;
		status_word[`STAT_TERM_ALL_OFF_BIT] = term_off_sync;
		status_word[`STAT_EVENT_THRESHOLD_BIT] = event_threshold_flag;
	end

	//--------------------------------
	// read multiplexer
	//--------------------------------
	reg [15:0] read_value;

	always @* begin
		case (reg_addr_in)
			`OFS_FIRMWARE_REVISION: begin
				read_value = FIRMWARE_REVISION;
			end
			`OFS_SLOT_POSITION: begin
				read_value = {11'h000, slot_position};
			end
			`OFS_CHAIN_BROADCAST_ADDRESS: begin
				read_value = byte_word(chain_address);
			end
			`OFS_CONTROL_SET: begin
				read_value = control_bits;
			end
			`OFS_CONTROL_CLEAR: begin
				read_value = control_bits;
			end
			`OFS_INTERRUPT_LEVEL: begin
				read_value = {13'h0000, interrupt_level};
			end
			`OFS_INTERRUPT_VECTOR: begin
				read_value = byte_word(interrupt_vector);
			end
			`OFS_MODULE_STATUS: begin
				read_value = status_word;
			end
			default: begin
				read_value = 16'h0000;
			end
		endcase
	end

	//--------------------------------
	// bus response
	//--------------------------------
	// unmapped or refused cycles get no acknowledge and time out
	// a write wins over a read, a read over an acknowledge
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_ack_out <= 1'b0;
			reg_rdata_out <= 16'h0000;
		end else if (write_taken) begin
			reg_ack_out <= 1'b1;
			reg_rdata_out <= 16'h0000;
		end else if (read_taken) begin
			reg_ack_out <= 1'b1;
			reg_rdata_out <= read_value;
		end else if (iack_taken) begin
			reg_ack_out <= 1'b1;
			reg_rdata_out <= byte_word(interrupt_vector);
		end else begin
			reg_ack_out <= 1'b0;
			reg_rdata_out <= 16'h0000;
		end
	end

	//--------------------------------
	// outputs
	//--------------------------------
	assign slot_position_out = slot_position;
	assign chain_broadcast_address_out = chain_address;
	assign base_from_relocation_out = control_bits[`CTRL_RELOCATION_BIT];
	assign bus_error_flag_out = control_bits[`CTRL_BUS_ERROR_BIT];
	assign module_reset_out = soft_reset_hold;
	assign interrupt_level_out = interrupt_level;
	assign interrupt_vector_out = interrupt_vector;
	assign local_data_ready_out = local_data_ready;
	assign local_busy_out = local_busy;
endmodule // vme_module_control_status_bank

// >>> testbench/vme_master_model.sv
`timescale 1ns/1ps
//--------------------------------
// register bus master model
//--------------------------------
module vme_master_model (
	input wire clk_in,
	input wire ack_in,
	output reg [15:0] addr_out,
	output reg [15:0] wdata_out,
	output reg write_out,
	output reg read_out,
	output reg iack_out
);
	initial begin
		addr_out = 16'h0000;
		wdata_out = 16'h0000;
		write_out = 1'b0;
		read_out = 1'b0;
		iack_out = 1'b0;
	end
	// kind 0 read, 1 write, 2 iack; got high if answered
	task access(input [1:0] kind, input [15:0] a, input [15:0] d, output got);
		integer n;
		begin
			@(posedge clk_in);
			#1;
			addr_out = a;
			wdata_out = d;
			read_out = (kind == 2'd0);
			write_out = (kind == 2'd1);
			iack_out = (kind == 2'd2);
			@(posedge clk_in);
			#1;
			got = ack_in;
			read_out = 1'b0;
			write_out = 1'b0;
			iack_out = 1'b0;
			// released bus does not keep last value
			addr_out = ~a;
			wdata_out = ~d;
			for (n = 0; n < 3; n = n + 1) begin
				@(posedge clk_in);
				#1;
				got = got | ack_in;
			end
		end
	endtask
endmodule // vme_master_model

// >>> testbench/vme_bank_sva.sv
`timescale 1ns/1ps
//--------------------------------
// register bank checker
//--------------------------------
module vme_bank_sva (
	input wire clk_in,
	input wire reset_in,
	input wire software_reset_in,
	input wire [15:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	input wire iack_in,
	input wire bus_error_event_in,
	input wire conversion_active_in,
	input wire [15:0] reg_rdata_out,
	input wire reg_ack_out,
	input wire [7:0] chain_broadcast_address_out,
	input wire base_from_relocation_out,
	input wire bus_error_flag_out,
	input wire module_reset_out,
	input wire [2:0] interrupt_level_out,
	input wire [7:0] interrupt_vector_out,
	input wire local_busy_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire rd_only = reg_read_in && !reg_write_in;
	wire iack_only = iack_in && !reg_read_in && !reg_write_in;
	wire wr_set = reg_write_in && reg_addr_in == 16'h1006;
	wire wr_clr = reg_write_in && reg_addr_in == 16'h1008;
	wire wd4 = reg_wdata_in[4];
	wire wd7 = reg_wdata_in[7];
	chk_reset_values: assert property ($fell(reset_in) |->
		chain_broadcast_address_out == 8'hAA && interrupt_level_out == 3'h0 && interrupt_vector_out == 8'h00)
		else $error("register values wrong after reset");
	chk_chain_read: assert property (rd_only && reg_addr_in == 16'h1004 |=>
		reg_ack_out && reg_rdata_out == {8'h00, $past(chain_broadcast_address_out)})
		else $error("broadcast address read wrong");
	chk_level_read: assert property (rd_only && reg_addr_in == 16'h100A |=>
		reg_ack_out && reg_rdata_out == {13'h0, $past(interrupt_level_out)})
		else $error("interrupt level read wrong");
	chk_vector_answer: assert property (iack_only && interrupt_level_out != 3'h0 |=>
		reg_ack_out && reg_rdata_out == {8'h00, $past(interrupt_vector_out)})
		else $error("vector not answered");
	chk_level_zero: assert property (iack_only && interrupt_level_out == 3'h0 |=> !reg_ack_out)
		else $error("acknowledge answered at level zero");
	chk_set_write: assert property (wr_set |=>
		base_from_relocation_out == ($past(base_from_relocation_out) | $past(wd4)))
		else $error("set write wrong");
	chk_clear_write: assert property (wr_clr |=>
		base_from_relocation_out == ($past(base_from_relocation_out) & !$past(wd4)))
		else $error("clear write wrong");
	chk_hold_keeps: assert property (module_reset_out && !(wr_clr && wd7) |=> module_reset_out)
		else $error("reset hold dropped");
	chk_error_set: assert property (bus_error_event_in |=> bus_error_flag_out)
		else $error("bus error flag not set");
	chk_error_clear: assert property (software_reset_in && !bus_error_event_in |=> !bus_error_flag_out)
		else $error("bus error flag not cleared");
	chk_busy_conv: assert property (conversion_active_in [*3] |-> local_busy_out)
		else $error("busy missing during conversion");
endmodule // vme_bank_sva

bind vme_module_control_status_bank vme_bank_sva u_vme_bank_sva (.clk_in, .reset_in, .software_reset_in,
	.reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .iack_in, .bus_error_event_in,
	.conversion_active_in, .reg_rdata_out, .reg_ack_out, .chain_broadcast_address_out,
	.base_from_relocation_out, .bus_error_flag_out, .module_reset_out, .interrupt_level_out,
	.interrupt_vector_out, .local_busy_out);

// >>> testbench/vme_module_control_status_bank_bench.sv
`timescale 1ns/1ps
module vme_module_control_status_bank_bench;
	// arbitrary revision value
	localparam [15:0] REV = 16'h0C07;
	reg clk_in = 1'b0, reset_in = 1'b1, sw_rst = 1'b0, aux = 1'b0, bus_err = 1'b0, irq = 1'b0;
	reg conv = 1'b0, full = 1'b0, memt = 1'b0, purged = 1'b0, cready = 1'b0, cbusy = 1'b0;
	reg ton = 1'b1, toff = 1'b0, got;
	reg [4:0] slot_lines = 5'h0B, stored = 5'h00, trigger = 5'h00;
	reg [15:0] v;
	reg [31:0] r;
	reg [15:0] expq[$];
	wire [15:0] addr, wdata, rdata;
	wire wr_s, rd_s, iack, ack;
	wire [4:0] slot;
	wire ldr;
	integer err_total = 0, compares = 0, i;
	vme_module_control_status_bank #(.FIRMWARE_REVISION(REV)) u_vme_module_control_status_bank (
		.clk_in(clk_in), .reset_in(reset_in), .software_reset_in(sw_rst), .aux_slot_connector_in(aux),
		.slot_lines_in(slot_lines), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
		.reg_read_in(rd_s), .iack_in(iack), .bus_error_event_in(bus_err), .events_stored_in(stored),
		.event_trigger_in(trigger), .irq_requested_in(irq), .conversion_active_in(conv),
		.buffer_full_in(full), .memory_test_in(memt), .chain_purged_in(purged), .chain_ready_line_in(cready),
		.chain_busy_line_in(cbusy), .term_all_on_in(ton), .term_all_off_in(toff), .reg_rdata_out(rdata),
		.reg_ack_out(ack), .slot_position_out(slot), .chain_broadcast_address_out(),
		.base_from_relocation_out(), .bus_error_flag_out(), .module_reset_out(), .interrupt_level_out(),
		.interrupt_vector_out(), .local_data_ready_out(ldr), .local_busy_out());
	vme_master_model u_vme_master_model (.clk_in(clk_in), .ack_in(ack), .addr_out(addr),
		.wdata_out(wdata), .write_out(wr_s), .read_out(rd_s), .iack_out(iack));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	//--------------------------------
	// tasks
	//--------------------------------
	task check(input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task rd_exp(input [15:0] a, input [15:0] e);
		begin
			expq.push_back(e);
			u_vme_master_model.access(2'd0, a, 16'h0000, got);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		begin
			expq.push_back(16'h0000);
			u_vme_master_model.access(2'd1, a, d, got);
		end
	endtask
	task hw_reset;
		begin
			reset_in = 1'b1;
			repeat (3) @(posedge clk_in);
			#1 reset_in = 1'b0;
			repeat (12) @(posedge clk_in);
		end
	endtask
	task pulse_sw;
		begin
			@(posedge clk_in);
			#1 sw_rst = 1'b1;
			@(posedge clk_in);
			#1 sw_rst = 1'b0;
			repeat (12) @(posedge clk_in);
		end
	endtask
	task conclude;
		begin
			check({15'h0, expq.size() != 0}, 16'h0000);
			$display("compares %0d err_total %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	//--------------------------------
	// answer monitor
	//--------------------------------
	always @(posedge clk_in) begin
		if (ack === 1'b1) begin
			if (expq.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(rdata, expq.pop_front());
		end
	end
	initial begin
		#100000;
		err_total = err_total + 1;
		conclude;
	end
	//--------------------------------
	// tests
	//--------------------------------
	initial begin
		r = $urandom(77);
		hw_reset;
		rd_exp(16'h1000, REV);
		rd_exp(16'h1002, 16'h001F);
		rd_exp(16'h1004, 16'h00AA);
		rd_exp(16'h1006, 16'h0000);
		rd_exp(16'h100A, 16'h0000);
		rd_exp(16'h100C, 16'h0000);
		rd_exp(16'h100E, 16'h0050);
		for (i = 0; i < 4; i = i + 1) begin
			r = $urandom;
			v = r[15:0];
			wr(16'h1004, v);
			wr(16'h100A, v);
			wr(16'h100C, v);
			rd_exp(16'h1004, {8'h00, v[7:0]});
			rd_exp(16'h100A, {13'h0, v[2:0]});
			rd_exp(16'h100C, {8'h00, v[7:0]});
		end
		wr(16'h1000, 16'hFFFF);
		rd_exp(16'h1000, REV);
		wr(16'h1006, 16'hFF70);
		rd_exp(16'h1006, 16'h0010);
		wr(16'h1006, 16'h0008);
		rd_exp(16'h1008, 16'h0018);
		wr(16'h1008, 16'h0000);
		rd_exp(16'h1006, 16'h0018);
		wr(16'h1008, 16'h0008);
		rd_exp(16'h1006, 16'h0010);
		wr(16'h1006, 16'h0080);
		pulse_sw;
		rd_exp(16'h1006, 16'h0090);
		rd_exp(16'h100E, 16'h0054);
		wr(16'h1008, 16'h0080);
		repeat (12) @(posedge clk_in);
		#1 bus_err = 1'b1;
		@(posedge clk_in);
		#1 bus_err = 1'b0;
		rd_exp(16'h1006, 16'h0018);
		pulse_sw;
		rd_exp(16'h1006, 16'h0010);
		wr(16'h100A, 16'h0000);
		u_vme_master_model.access(2'd2, 16'h0000, 16'h0000, got);
		check({15'h0, got}, 16'h0000);
		wr(16'h100A, 16'h0003);
		wr(16'h100C, 16'h005A);
		expq.push_back(16'h005A);
		u_vme_master_model.access(2'd2, 16'h0000, 16'h0000, got);
		u_vme_master_model.access(2'd0, 16'h1010, 16'h0000, got);
		check({15'h0, got}, 16'h0000);
		wr(16'h1002, 16'h0005);
		check({11'h0, slot}, 16'h001F);
		pulse_sw;
		rd_exp(16'h1002, 16'h0005);
		check({11'h0, slot}, 16'h0005);
		aux = 1'b1;
		hw_reset;
		rd_exp(16'h1002, 16'h000B);
		u_vme_master_model.access(2'd1, 16'h1002, 16'h0003, got);
		check({15'h0, got}, 16'h0000);
		slot_lines = 5'h16;
		pulse_sw;
		rd_exp(16'h1002, 16'h0016);
		for (i = 0; i < 8; i = i + 1) begin
			r = $urandom;
			wr(16'h100A, {13'h0, r[21:19]});
			@(posedge clk_in);
			#1 {conv, full, memt, purged, cready, cbusy, irq} = r[6:0];
			stored = r[11:7];
			trigger = r[16:12];
			ton = r[17];
			toff = r[18] & ~r[17];
			repeat (8) @(posedge clk_in);
			rd_exp(16'h100E, {7'h0, trigger >= stored && irq && r[21:19] != 3'h0,
				toff, ton, purged, ~aux, cbusy, conv | full | memt, cready, stored != 5'h00});
			check({15'h0, ldr}, {15'h0, stored != 5'h00});
		end
		repeat (6) @(posedge clk_in);
		conclude;
	end
endmodule // vme_module_control_status_bank_bench
